/* design/rtca_alarm_ctrl.sv */
// The address map and register access over AHB-Lite are this design's own decisions.
module rtca_alarm_ctrl #(
  parameter int unsigned PRESC_W = 16
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  input  wire logic                       rtc_on,
  input  wire logic                       half_sec_tick,
  input  wire logic [PRESC_W-1:0]         presc_left,
  input  wire logic [rtca_pkg::NUM_PERIODS-1:0] period_match,
  output logic                            alarm_pulse,
  output logic                            alarm_event
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                        ready;
    logic                        wr_pend;
    logic [rtca_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0]                 rdata;
    logic                        arm;
    logic                        chime;
    logic                        pulse;
    logic [3:0]                  period;
    logic [7:0]                  rpt;
    logic [15:0]                 evt_cnt;
    logic                        evt;
  } rtca_state_s;

  localparam int unsigned STAT_W = 11;

  rtca_state_s      r_q;
  rtca_state_s      r_d;
  logic [STAT_W-1:0] stat_raw;
  logic [STAT_W-1:0] stat_sync;
  logic              near_raw;
  logic              arm_s;
  logic              pulse_s;
  logic              near_s;
  logic [7:0]        rpt_s;
  logic              period_hit;
  logic              fire;
  logic              addr_phase;
  logic [rtca_pkg::NUM_PERIODS-1:0] sel_match;

  // ----------------------------------------------------------------
  // Rollover proximity
  // ----------------------------------------------------------------
  // RULE6: far from rollover
  // RULE7: near rollover flags
  // Stopped prescaler never rolls over, so flag stays low while off
  assign near_raw = rtc_on &&
                    (presc_left <= PRESC_W'(rtca_pkg::NEAR_CLKS));

  // ----------------------------------------------------------------
  // Status crossing toward bus reads
  // ----------------------------------------------------------------
  // RULE9: synchronise status
  assign stat_raw = {r_q.arm, r_q.pulse, near_raw, r_q.rpt};

  rtca_sync #(
    .W (STAT_W)
  ) u_stat_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (stat_raw),
    .q     (stat_sync)
  );

  assign arm_s   = stat_sync[10];
  assign pulse_s = stat_sync[9];
  assign near_s  = stat_sync[8];
  assign rpt_s   = stat_sync[7:0];

  // ----------------------------------------------------------------
  // Period selection
  // ----------------------------------------------------------------
  // RULE11: short period codes
  // RULE12: long period codes
  // Leap-day yearly alarms rely on the comparator only matching real dates
  genvar gi;
  generate
    for (gi = 0; gi < rtca_pkg::NUM_PERIODS; gi++) begin : g_sel
      assign sel_match[gi] = period_match[gi] && (r_q.period == 4'(gi));
    end
  endgenerate

  // Reserved codes select no match line
  assign period_hit = |sel_match;

  // RULE1: arm gates events
  assign fire = r_q.arm && half_sec_tick && period_hit;

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  assign addr_phase = hsel && hready && (htrans == rtca_pkg::HTRANS_NONSEQ);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d       = r_q;
    r_d.ready = 1'b1;
    r_d.evt   = 1'b0;

    // Address phase: capture writes, answer reads one cycle later
    r_d.wr_pend = 1'b0;
    if (addr_phase && hwrite && (hsize == rtca_pkg::HSIZE_WORD)) begin
      r_d.wr_pend = 1'b1;
      r_d.wr_addr = haddr[rtca_pkg::ADDR_W-1:0];
    end
    if (addr_phase && !hwrite) begin
      case (haddr[rtca_pkg::ADDR_W-1:0])
        rtca_pkg::ALARM_CTRL_OFS: begin
          r_d.rdata = '0;
          // RULE5: live pulse level
          r_d.rdata[rtca_pkg::ARM_BIT]   = arm_s;
          r_d.rdata[rtca_pkg::CHIME_BIT] = r_q.chime;
          r_d.rdata[rtca_pkg::PULSE_BIT] = pulse_s;
          // RULE7: flag reported
          r_d.rdata[rtca_pkg::NEAR_BIT]  = near_s;
          r_d.rdata[rtca_pkg::PERIOD_LSB +: 4] = r_q.period;
          r_d.rdata[rtca_pkg::RPT_LSB +: 8]    = rpt_s;
        end
        rtca_pkg::EVENT_COUNT_OFS: begin
          r_d.rdata = {16'h0000, r_q.evt_cnt};
        end
        default: begin
          r_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Data phase write
    if (r_q.wr_pend) begin
      case (r_q.wr_addr)
        rtca_pkg::ALARM_CTRL_OFS: begin
          // RULE1: software arm control
          r_d.arm    = hwdata[rtca_pkg::ARM_BIT];
          r_d.chime  = hwdata[rtca_pkg::CHIME_BIT];
          r_d.period = hwdata[rtca_pkg::PERIOD_LSB +: 4];
          r_d.rpt    = hwdata[rtca_pkg::RPT_LSB +: 8];
          // RULE4: initial level load
          // RULE5: armed ignores write
          if (!r_q.arm) begin
            r_d.pulse = hwdata[rtca_pkg::PULSE_BIT];
          end
        end
        rtca_pkg::EVENT_COUNT_OFS: begin
          r_d.evt_cnt = rtca_pkg::EVT_CNT_RST;
        end
        default: begin
          r_d.evt_cnt = r_q.evt_cnt;
        end
      endcase
    end

    // Alarm event; hardware update wins over a same-cycle write
    if (fire) begin
      r_d.evt     = 1'b1;
      r_d.evt_cnt = r_q.evt_cnt + 16'h0001;
      // RULE16: toggle pulse
      r_d.pulse   = !r_q.pulse;
      if (r_q.rpt != rtca_pkg::RPT_RST) begin
        // RULE16: decrement count
        r_d.rpt = r_q.rpt - 8'h01;
      end else if (r_q.chime) begin
        // RULE2: chime wraps
        r_d.rpt = rtca_pkg::RPT_MAX;
      end else begin
        // RULE3: stop at zero
        r_d.rpt = rtca_pkg::RPT_RST;
        // RULE13: hardware disarm
        r_d.arm = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // RULE15: power-on reset only
  // Other system resets must not be wired to rst_b
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      r_q         <= '0;
      r_q.ready   <= 1'b1;
      r_q.period  <= rtca_pkg::PERIOD_RST;
      r_q.rpt     <= rtca_pkg::RPT_RST;
      r_q.evt_cnt <= rtca_pkg::EVT_CNT_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout   = r_q.ready;
  assign hresp       = 1'b0;
  assign hrdata      = r_q.rdata;
  assign alarm_pulse = r_q.pulse;
  assign alarm_event = r_q.evt;

endmodule

/* design/rtca_pkg.sv */
// Behaviour
// RULE1: Setting the alarm arm bit enables alarm generation and clearing it stops all alarm events.
// RULE2: With chime set, the eight-bit repeat count wraps from 0x00 to 0xFF on an event and keeps going.
// RULE3: With chime clear, the repeat count stops at 0x00 and does not wrap.
// RULE4: While disarmed, the pulse initial value bit is writable and sets the alarm pulse level.
// RULE5: While armed, writes to the pulse initial value bit are ignored and reads show the live pulse.
// RULE6: The rollover-near flag reads 0 when the prescaler is more than 32 RTC clocks from rollover.
// RULE7: The rollover-near flag reads 1 when a half-second rollover may change count and arm bit.
// RULE8: While the rollover-near flag is set, software rereads the count until two reads agree.
// RULE9: Status that changes with RTC time passes a two-stage synchroniser before any bus read; the event count is read straight from evt_cnt, unsynchronised.
// RULE10: Software finishes a read of the alarm register within 32 bus clocks.
// RULE11: Period codes 0000 to 0101 select half-second, second, 10 s, minute, 10 min and hour.
// RULE12: Codes 0110 to 1001 select day, week, month, year; 1010 to 1111 are reserved and never fire.
// RULE13: An event with count 0x00 and chime clear clears the alarm arm bit in hardware.
// RULE14: Software leaves the control fields alone while the RTC is on and the near flag is set.
// RULE15: The alarm control register is cleared only by power-on reset.
// RULE16: Each alarm event decrements the repeat count, with wrap or stop, and toggles the pulse.
package rtca_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned         ADDR_W           = 8;
  localparam logic [ADDR_W-1:0]   ALARM_CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0]   EVENT_COUNT_OFS  = 8'h04;

  // ----------------------------------------------------------------
  // Field positions of alarm_control
  // ----------------------------------------------------------------
  localparam int unsigned ARM_BIT     = 15;
  localparam int unsigned CHIME_BIT   = 14;
  localparam int unsigned PULSE_BIT   = 13;
  localparam int unsigned NEAR_BIT    = 12;
  localparam int unsigned PERIOD_LSB  = 8;
  localparam int unsigned RPT_LSB     = 0;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  RPT_RST     = 8'h00;
  localparam logic [7:0]  RPT_MAX     = 8'hFF;
  localparam logic [3:0]  PERIOD_RST  = 4'h0;
  localparam logic [15:0] EVT_CNT_RST = 16'h0000;
  localparam int unsigned NEAR_CLKS   = 32;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Alarm period codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PER_HALF_SEC = 4'b0000,
    PER_SECOND   = 4'b0001,
    PER_TEN_SEC  = 4'b0010,
    PER_MINUTE   = 4'b0011,
    PER_TEN_MIN  = 4'b0100,
    PER_HOUR     = 4'b0101,
    PER_DAY      = 4'b0110,
    PER_WEEK     = 4'b0111,
    PER_MONTH    = 4'b1000,
    PER_YEAR     = 4'b1001
  } rtca_period_e;

  localparam int unsigned NUM_PERIODS = 10;

  // AHB transfer and size codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

endpackage

/* design/rtca_sync.sv */
module rtca_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rtca_sync_s;

  rtca_sync_s s_q;
  rtca_sync_s s_d;

  // First stage feeds only the second
  always_comb begin
    s_d        = s_q;
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;

endmodule

/* tb/rtca_alarm_checker.sv */
module rtca_alarm_checker #(
  parameter int unsigned PRESC_W = 16
) (
  input wire logic               mclk,
  input wire logic               rst_b,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic               rtc_on,
  input wire logic               half_sec_tick,
  input wire logic [PRESC_W-1:0] presc_left,
  input wire logic [9:0]         period_match,
  input wire logic               alarm_pulse,
  input wire logic               alarm_event
);
  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  logic rd_q, rd0_q, rdx_q, wr_q;
  wire  take_w = hsel && hready && (htrans == rtca_pkg::HTRANS_NONSEQ);
  wire  far_w  = !rtc_on || (presc_left > 32);
  wire  near_w = rtc_on && (presc_left <= 32);
  always_ff @(posedge mclk) begin
    rd_q  <= rst_b && take_w && !hwrite;
    rd0_q <= rst_b && take_w && !hwrite && (haddr[7:0] == rtca_pkg::ALARM_CTRL_OFS);
    rdx_q <= rst_b && take_w && !hwrite && (haddr[7:0] > rtca_pkg::EVENT_COUNT_OFS);
    wr_q  <= rst_b && take_w && hwrite;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Six cycles, to cover the synchroniser and the read register
  sequence s_far;  far_w [*6];  endsequence
  sequence s_near; near_w [*6]; endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_HI_ZERO: assert property (rd_q |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (rdx_q |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_FAR: assert property (s_far ##0 rd0_q |-> !hrdata[12])
    else $error("near flag set while far");
  AST_NEAR: assert property (s_near ##0 rd0_q |-> hrdata[12])
    else $error("near flag clear while near");
  AST_CAUSE: assert property (alarm_event |->
    $past(half_sec_tick) && $past(period_match) != 10'h000)
    else $error("event without tick and match");
  AST_TOGGLE: assert property (alarm_event |-> alarm_pulse != $past(alarm_pulse))
    else $error("pulse not toggled on event");
  AST_PULSE_HOLD: assert property ($changed(alarm_pulse) |->
    alarm_event || $past(wr_q) || $past(wr_q, 2))
    else $error("pulse changed without cause");
endmodule

bind rtca_alarm_ctrl rtca_alarm_checker #(.PRESC_W(PRESC_W)) u_chk (.mclk(mclk), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rtc_on(rtc_on),
  .half_sec_tick(half_sec_tick), .presc_left(presc_left), .period_match(period_match),
  .alarm_pulse(alarm_pulse), .alarm_event(alarm_event));

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = rtca_pkg::ALARM_CTRL_OFS;
  localparam logic [7:0] EVC = rtca_pkg::EVENT_COUNT_OFS;
  logic        mclk, rst_b, hsel, hwrite, hreadyout, hresp, rtc_on, half_sec_tick;
  logic        alarm_pulse, alarm_event, arm, chime, alarm_pulse_init, fire;
  logic [31:0] haddr, hwdata, hrdata, r, r0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] presc_left, evc;
  logic [9:0]  period_match, m;
  logic [3:0]  per;
  logic [7:0]  rpt;
  int          failures, n_compared;
  rtca_alarm_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rtc_on(rtc_on), .half_sec_tick(half_sec_tick),
    .presc_left(presc_left), .period_match(period_match), .alarm_pulse(alarm_pulse),
    .alarm_event(alarm_event));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s", $time, s);
    end
  endtask
  // Never trust a fixed latency: hang cut by bound
  task automatic rdy();
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 16);
    if (hreadyout !== 1'b1) begin
      chk(0, 1, "ready timeout");
      final_report();
    end
  endtask
  // two phases, 16 cycles each at most
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= rtca_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  function automatic logic [31:0] ctl_exp();
    return {16'h0000, arm, chime, alarm_pulse_init, 1'b0, per, rpt};
  endfunction
  function automatic logic [7:0] rpt_next(input logic [7:0] v, input logic c);
    return (v == 8'h00) ? (c ? 8'hFF : 8'h00) : v - 8'h01;
  endfunction
  // Status lags two cycles through the synchroniser
  task automatic rdc(input string s);
    repeat (3) @(posedge mclk);
    xfer(1'b0, CTL, 32'h0);
    chk(r, ctl_exp(), s);
    chk({31'h0, alarm_pulse}, {31'h0, alarm_pulse_init}, "pulse pin");
  endtask
  initial begin
    #800000;
    chk(0, 1, "run timeout");
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hsel          = 1'b0;
    haddr         = 32'h0000_0000;
    htrans        = 2'b00;
    hwrite        = 1'b0;
    hsize         = rtca_pkg::HSIZE_WORD;
    hwdata        = 32'h0000_0000;
    rtc_on        = 1'b0;
    half_sec_tick = 1'b0;
    presc_left    = 16'hFFFF;
    period_match  = 10'h000;
    rst_b         = 1'b0;
    failures      = 0;
    n_compared    = 0;
    evc           = 16'h0000;
    arm           = 1'b0;
    chime         = 1'b0;
    alarm_pulse_init           = 1'b0;
    per           = 4'h0;
    rpt           = 8'h00;
    void'($urandom(32'hce7c948a));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rdc("control reset");
    // Narrow writes are refused
    hsize <= 3'b000;
    xfer(1'b1, CTL, 32'h0000_A5A5);
    hsize <= rtca_pkg::HSIZE_WORD;
    rdc("narrow write ignored");
    xfer(1'b0, 8'h08, 32'h0000_0000);
    chk(r, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    alarm_pulse_init = 1'b1;
    xfer(1'b1, CTL, ctl_exp());
    rdc("pulse written");
    arm = 1'b1;
    xfer(1'b1, CTL, ctl_exp());
    xfer(1'b1, CTL, ctl_exp() & 32'hFFFF_DFFF);
    rdc("pulse locked");
    $display("test pulse done");
    for (int i = 0; i < 26; i++) begin
      chime = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom_range(0, 1));
      rpt   = (i < 2) ? 8'h00 : 8'($urandom_range(0, 3));
      per   = (i < 20) ? 4'(i % 10) : 4'(i - 10);
      alarm_pulse_init   = 1'($urandom_range(0, 1));
      arm   = 1'b0;
      xfer(1'b1, CTL, ctl_exp());
      arm   = 1'b1;
      xfer(1'b1, CTL, ctl_exp());
      for (int k = 0; k < 3; k++) begin
        m = 10'($urandom);
        if (k == 0) m = m | (10'h001 << per);
        if (per > 4'h9) m = 10'h3FF;
        fire = arm && (per < 4'hA) && m[per];
        @(posedge mclk);
        half_sec_tick <= 1'b1;
        period_match  <= m;
        @(posedge mclk);
        half_sec_tick <= 1'b0;
        #1;
        chk({31'h0, alarm_event}, {31'h0, fire}, "alarm event");
        if (fire) begin
          alarm_pulse_init = ~alarm_pulse_init;
          evc++;
          if (rpt == 8'h00 && !chime) arm = 1'b0;
          rpt = rpt_next(rpt, chime);
        end
        rdc("control after event");
      end
    end
    xfer(1'b0, EVC, 32'h0000_0000);
    chk(r, {16'h0000, evc}, "event count");
    // Count clear lands on the edge that ends the data phase
    xfer(1'b1, EVC, 32'h0000_0000);
    @(posedge mclk);
    xfer(1'b0, EVC, 32'h0000_0000);
    chk(r, 32'h0000_0000, "event count clear");
    $display("test alarms done");
    for (int j = 0; j < 5; j++) begin
      @(posedge mclk);
      rtc_on <= (j < 4);
      if (j == 3) begin
        presc_left <= 16'($urandom_range(33, 65535));
      end else begin
        presc_left <= (j == 0) ? 16'h0021 : (j == 1) ? 16'h0020 : 16'h0000;
      end
      repeat (6) @(posedge mclk);
      xfer(1'b0, CTL, 32'h0000_0000);
      r0 = r;
      xfer(1'b0, CTL, 32'h0000_0000);
      for (int n = 0; n < 4 && r !== r0; n++) begin
        r0 = r;
        xfer(1'b0, CTL, 32'h0000_0000);
      end
      chk({31'h0, r[12]}, {31'h0, (j == 1 || j == 2)}, "near flag");
    end
    $display("test near done");
    final_report();
  end
endmodule
